// [core/asc_scan_ctrl.sv]
/*
 * scan and single conversion control: configuration, sequencing,
 * result formatting, interrupt enable and flags.
 * assumes a converter that takes a start pulse and a channel and
 * later returns one raw sample with a one-cycle done pulse.
 */
`timescale 1ns/100ps
module asc_scan_ctrl #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata_q,
    // converter port
    output logic                   conv_start_q,
    output logic      [2:0]        conv_chan_q,
    output logic                   conv_input_pair_mode_q,
    input  wire logic              conv_done,
    input  wire logic [11:0]       conv_data,
    // status
    output logic                   irq_q,
    output logic                   seq_active_q
);
    asc_pkg::asc_state_t state_q, state_d;
    logic        scan_q, scan_d;
    logic [2:0]  idx_q, idx_d;
    logic [23:0] acc_q, acc_d;
    logic [12:0] cnt_q, cnt_d;
    logic [31:0] cfg_q, cfg_d;
    logic [31:0] ctl_q, ctl_d;
    logic [9:0]  ien_q, ien_d;
    logic [15:0] sdata_q, sdata_d;
    logic [15:0] qdata_q, qdata_d;
    logic        svld_q, svld_d;
    logic        qvld_q, qvld_d;
    logic        start_d;
    logic [2:0]  chan_d;
    logic        input_pair_mode_d;
    logic        active_d;
    logic [31:0] rdata_d;
    logic [9:0]  hw_set;
    logic [9:0]  sw_set;
    logic [9:0]  sw_clr;
    logic [9:0]  flag_q;

    // decoded fields
    logic                 wr_cmd;
    logic                 cfg_rep;
    logic                 cfg_input_pair_mode;
    logic                 cfg_adj;
    asc_pkg::asc_res_t    cfg_res;
    logic [7:0]           cfg_mask;
    logic [3:0]           ovs_rate;
    logic [12:0]          ovs_last;
    logic [23:0]          sum;
    logic [27:0]          ovs_wide;
    logic [15:0]          val;
    logic [4:0]           lsh;
    logic [15:0]          result;
    logic [3:0]           nxt;
    logic [3:0]           first;

    // lowest selected input at or above from; bit 3 set when none
    function automatic logic [3:0] next_sel(input logic [7:0] mask,
                                            input logic [3:0] from,
                                            input logic       input_pair_mode);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if ((4'(i) >= from) && mask[i] && (!input_pair_mode || i < 4)) begin
                r = {1'b0, 3'(i)};
            end
        end
        return r;
    endfunction : next_sel

    always_comb begin
        wr_cmd   = reg_wr && (reg_addr == ADDR_W'(asc_pkg::OFF_CMD));
        cfg_rep  = cfg_q[asc_pkg::CFG_REP];
        cfg_input_pair_mode = cfg_q[asc_pkg::CFG_INPUT_PAIR_MODE];
        cfg_adj  = cfg_q[asc_pkg::CFG_ADJ];
        cfg_res  = asc_pkg::asc_res_t'(cfg_q[asc_pkg::CFG_RES +: 2]);
        cfg_mask = cfg_q[asc_pkg::CFG_MASK +: 8];
        ovs_rate = ctl_q[asc_pkg::CTL_OVS +: 4];
        if (ovs_rate > asc_pkg::OVS_MAX) begin
            ovs_rate = asc_pkg::OVS_MAX;
        end
        ovs_last = 13'((14'h0002 << ovs_rate) - 14'h0001);
        sum      = acc_q + {12'h000, conv_data};
        ovs_wide = {sum, 4'h0} >> (ovs_rate + 4'h1);
        // result width per resolution
        unique case (cfg_res)
            asc_pkg::twelve_bit_code: begin
                val = {4'h0, conv_data};
                lsh = asc_pkg::LSH_TWELVE;
            end
            asc_pkg::eight_bit_code: begin
                val = {8'h00, conv_data[11:4]};
                lsh = asc_pkg::LSH_EIGHT;
            end
            asc_pkg::six_bit_code: begin
                val = {10'h000, conv_data[11:6]};
                lsh = asc_pkg::LSH_SIX;
            end
            asc_pkg::oversample_code: begin
                val = ovs_wide[15:0];
                lsh = 5'h00;
            end
        endcase
        result = cfg_adj ? (val << lsh) : val;
        first  = next_sel(cfg_mask, 4'h0, cfg_input_pair_mode);
        nxt    = next_sel(cfg_mask, {1'b0, idx_q} + 4'h1, cfg_input_pair_mode);
    end

    // register writes
    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        ien_d = ien_q;
        if (reg_wr && reg_addr == ADDR_W'(asc_pkg::OFF_SCANCFG)) begin
            cfg_d = reg_wdata & asc_pkg::CFG_WMASK;
        end
        if (reg_wr && reg_addr == ADDR_W'(asc_pkg::OFF_CTRL)) begin
            ctl_d = reg_wdata & asc_pkg::CTL_WMASK;
        end
        if (reg_wr && reg_addr == ADDR_W'(asc_pkg::OFF_IEN)) begin
            ien_d = reg_wdata[9:0] & asc_pkg::FLG_IMPL;
        end
        sw_set = (reg_wr && reg_addr == ADDR_W'(asc_pkg::OFF_IFS)) ? reg_wdata[9:0] : 10'h000;
        sw_clr = (reg_wr && reg_addr == ADDR_W'(asc_pkg::OFF_IFC)) ? reg_wdata[9:0] : 10'h000;
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        scan_d  = scan_q;
        idx_d   = idx_q;
        acc_d   = acc_q;
        cnt_d   = cnt_q;
        sdata_d = sdata_q;
        qdata_d = qdata_q;
        svld_d  = svld_q;
        qvld_d  = qvld_q;
        start_d = 1'b0;
        chan_d  = conv_chan_q;
        input_pair_mode_d  = conv_input_pair_mode_q;
        hw_set  = 10'h000;
        // reading a result frees its slot
        if (reg_rd && reg_addr == ADDR_W'(asc_pkg::OFF_SDATA)) begin
            svld_d = 1'b0;
        end
        if (reg_rd && reg_addr == ADDR_W'(asc_pkg::OFF_QDATA)) begin
            qvld_d = 1'b0;
        end
        unique case (state_q)
            asc_pkg::st_idle: begin
                if (wr_cmd && reg_wdata[asc_pkg::CMD_SEQ_START] && !first[3]) begin
                    scan_d  = 1'b1;
                    idx_d   = first[2:0];
                    state_d = asc_pkg::st_start;
                end else if (wr_cmd && reg_wdata[asc_pkg::CMD_SINGLE_START]) begin
                    scan_d  = 1'b0;
                    idx_d   = ctl_q[asc_pkg::CTL_SCHAN +: 3];
                    state_d = asc_pkg::st_start;
                end
            end
            asc_pkg::st_start: begin
                start_d = 1'b1;
                input_pair_mode_d  = scan_q && cfg_input_pair_mode;
                chan_d  = input_pair_mode_d ? {idx_q[1:0], 1'b0} : idx_q;
                state_d = asc_pkg::st_wait;
            end
            asc_pkg::st_wait: begin
                if (conv_done) begin
                    if (cfg_res == asc_pkg::oversample_code && cnt_q != ovs_last) begin
                        acc_d   = sum;
                        cnt_d   = cnt_q + 13'h0001;
                        state_d = asc_pkg::st_start;
                    end else begin
                        acc_d = 24'h00_0000;
                        cnt_d = 13'h0000;
                        if (!scan_q) begin
                            hw_set[asc_pkg::FLG_SINGLE]    = 1'b1;
                            hw_set[asc_pkg::FLG_SINGLE_OF] = svld_d;
                            sdata_d = result;
                            svld_d  = 1'b1;
                            state_d = asc_pkg::st_idle;
                        end else begin
                            hw_set[asc_pkg::FLG_SCAN_OF] = qvld_d;
                            qdata_d = result;
                            qvld_d  = 1'b1;
                            if (!nxt[3]) begin
                                idx_d   = nxt[2:0];
                                state_d = asc_pkg::st_start;
                            end else begin
                                hw_set[asc_pkg::FLG_SCAN] = 1'b1;
                                if (cfg_rep && !first[3]) begin
                                    idx_d   = first[2:0];
                                    state_d = asc_pkg::st_start;
                                end else begin
                                    state_d = asc_pkg::st_idle;
                                end
                            end
                        end
                    end
                end
            end
        endcase
        // halt drops the conversion in flight
        if (wr_cmd && state_q != asc_pkg::st_idle &&
            ((scan_q && reg_wdata[asc_pkg::CMD_SEQ_HALT]) ||
             (!scan_q && reg_wdata[asc_pkg::CMD_SINGLE_HALT]))) begin
            state_d = asc_pkg::st_idle;
            start_d = 1'b0;
            acc_d   = 24'h00_0000;
            cnt_d   = 13'h0000;
            hw_set  = 10'h000;
        end
        active_d = scan_d && (state_d != asc_pkg::st_idle);
    end

    // read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_W'(asc_pkg::OFF_CTRL):    rdata_d = ctl_q;
                ADDR_W'(asc_pkg::OFF_STATUS):  rdata_d = {28'h000_0000, qvld_q, svld_q,
                                                          seq_active_q,
                                                          state_q != asc_pkg::st_idle};
                ADDR_W'(asc_pkg::OFF_SCANCFG): rdata_d = cfg_q;
                ADDR_W'(asc_pkg::OFF_IEN):     rdata_d = {22'h00_0000, ien_q};
                ADDR_W'(asc_pkg::OFF_IF):      rdata_d = {22'h00_0000, flag_q};
                ADDR_W'(asc_pkg::OFF_SDATA):   rdata_d = {16'h0000, sdata_q};
                ADDR_W'(asc_pkg::OFF_QDATA):   rdata_d = {16'h0000, qdata_q};
                default:                       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q      <= asc_pkg::st_idle;
            scan_q       <= 1'b0;
            idx_q        <= 3'h0;
            acc_q        <= 24'h00_0000;
            cnt_q        <= 13'h0000;
            cfg_q        <= asc_pkg::CFG_RST;
            ctl_q        <= asc_pkg::CTL_RST;
            ien_q        <= asc_pkg::IEN_RST;
            sdata_q      <= 16'h0000;
            qdata_q      <= 16'h0000;
            svld_q       <= 1'b0;
            qvld_q       <= 1'b0;
            conv_start_q <= 1'b0;
            conv_chan_q  <= 3'h0;
            conv_input_pair_mode_q  <= 1'b0;
            seq_active_q <= 1'b0;
            reg_rdata_q  <= 32'h0000_0000;
        end else begin
            state_q      <= state_d;
            scan_q       <= scan_d;
            idx_q        <= idx_d;
            acc_q        <= acc_d;
            cnt_q        <= cnt_d;
            cfg_q        <= cfg_d;
            ctl_q        <= ctl_d;
            ien_q        <= ien_d;
            sdata_q      <= sdata_d;
            qdata_q      <= qdata_d;
            svld_q       <= svld_d;
            qvld_q       <= qvld_d;
            conv_start_q <= start_d;
            conv_chan_q  <= chan_d;
            conv_input_pair_mode_q  <= input_pair_mode_d;
            seq_active_q <= active_d;
            reg_rdata_q  <= rdata_d;
        end
    end

    asc_flags #(
        .N    (asc_pkg::FLAG_W),
        .IMPL (asc_pkg::FLG_IMPL)
    ) u_flags (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .hw_set   (hw_set),
        .sw_set   (sw_set),
        .sw_clr   (sw_clr),
        .enable_d (ien_d),
        .flag_q   (flag_q),
        .irq_q    (irq_q)
    );
endmodule : asc_scan_ctrl

// [core/asc_pkg.sv]
/*
 * constants, field layouts and types of the scan configuration and
 * interrupt enable block.
 * assumes one 100 MHz clock and a word-wide register port.
 */
package asc_pkg;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned RAW_W      = 12;
    localparam int unsigned RESULT_W   = 16;
    localparam int unsigned ACC_W      = 24;
    localparam int unsigned FLAG_W     = 10;

    // byte offsets
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_CTRL    = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_SCANCFG = 8'h10;
    localparam logic [7:0] OFF_IEN     = 8'h14;
    localparam logic [7:0] OFF_IF      = 8'h18;
    localparam logic [7:0] OFF_IFS     = 8'h1c;
    localparam logic [7:0] OFF_IFC     = 8'h20;
    localparam logic [7:0] OFF_SDATA   = 8'h24;
    localparam logic [7:0] OFF_QDATA   = 8'h28;

    // command bits
    localparam int unsigned CMD_SINGLE_START = 0;
    localparam int unsigned CMD_SINGLE_HALT  = 1;
    localparam int unsigned CMD_SEQ_START    = 2;
    localparam int unsigned CMD_SEQ_HALT     = 3;

    // scan configuration fields
    localparam int unsigned CFG_REP    = 0;
    localparam int unsigned CFG_INPUT_PAIR_MODE   = 1;
    localparam int unsigned CFG_ADJ    = 2;
    localparam int unsigned CFG_RES    = 4;
    localparam int unsigned CFG_MASK   = 8;
    localparam logic [31:0] CFG_WMASK  = 32'h0000_ff37;
    localparam logic [31:0] CFG_RST    = 32'h0000_0000;

    // control fields
    localparam int unsigned CTL_OVS    = 0;
    localparam int unsigned CTL_SCHAN  = 8;
    localparam logic [31:0] CTL_WMASK  = 32'h0000_070f;
    localparam logic [31:0] CTL_RST    = 32'h0000_0000;
    localparam logic [3:0]  OVS_MAX    = 4'h b;

    // flag and enable bits
    localparam int unsigned FLG_SINGLE    = 0;
    localparam int unsigned FLG_SCAN      = 1;
    localparam int unsigned FLG_SINGLE_OF = 8;
    localparam int unsigned FLG_SCAN_OF   = 9;
    localparam logic [9:0]  FLG_IMPL      = 10'h303;
    localparam logic [9:0]  IEN_RST       = 10'h000;

    // left-align shift per resolution
    localparam logic [4:0] LSH_TWELVE = 5'h04;
    localparam logic [4:0] LSH_EIGHT  = 5'h08;
    localparam logic [4:0] LSH_SIX    = 5'h0a;

    typedef enum logic [1:0] {
        twelve_bit_code = 2'h0,
        eight_bit_code  = 2'h1,
        six_bit_code    = 2'h2,
        oversample_code = 2'h3
    } asc_res_t;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_start = 3'b010,
        st_wait  = 3'b100
    } asc_state_t;
endpackage : asc_pkg

// [core/asc_flags.sv]
/*
 * sticky interrupt flags with enable gating and one level interrupt.
 * assumes set, clear and enable inputs are synchronous to clk_sys.
 */
`timescale 1ns/100ps
module asc_flags #(
    parameter int unsigned     N    = 10,
    parameter logic [N-1:0]    IMPL = 10'h303
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // flag control
    input  wire logic [N-1:0]  hw_set,
    input  wire logic [N-1:0]  sw_set,
    input  wire logic [N-1:0]  sw_clr,
    input  wire logic [N-1:0]  enable_d,
    // state
    output logic      [N-1:0]  flag_q,
    output logic               irq_q
);
    logic [N-1:0] flag_d;
    logic         irq_d;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            if (IMPL[i]) begin : g_impl
                // set wins over clear
                always_comb begin
                    flag_d[i] = (flag_q[i] & ~sw_clr[i]) | hw_set[i] | sw_set[i];
                end
            end else begin : g_rsvd
                always_comb begin
                    flag_d[i] = 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        irq_d = |(flag_d & enable_d & IMPL);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flag_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= irq_d;
        end
    end
endmodule : asc_flags

// [bench/asc_scan_ctrl_props.sv]
/*
 * port-level checks of the scan control block.
 * assumes binding onto asc_scan_ctrl, one clock, synchronous reset.
 */
`timescale 1ns/100ps
module asc_scan_ctrl_props #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata_q,
    // converter and status
    input wire logic              conv_start_q,
    input wire logic [2:0]        conv_chan_q,
    input wire logic              conv_input_pair_mode_q,
    input wire logic              conv_done,
    input wire logic [11:0]       conv_data,
    input wire logic              irq_q,
    input wire logic              seq_active_q
);
    logic [9:0] ien_q;
    logic [9:0] ien_d;

    // shadow of the enable register
    always_comb begin
        ien_d = ien_q;
        if (reg_wr && reg_addr == 8'h14) begin
            ien_d = reg_wdata[9:0] & 10'h303;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ien_q <= 10'h000;
        end else begin
            ien_q <= ien_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
        else $error("read data not idle");
    chk_reset_quiet:
        assert property ($fell(reset) |-> !irq_q && !seq_active_q && !conv_start_q)
        else $error("outputs active after reset");
    chk_irq_mask_off:
        assert property (reg_wr && reg_addr == 8'h14 && reg_wdata[9:0] == 10'h000 |=> !irq_q)
        else $error("irq high with all enables off");
    chk_irq_raise:
        assert property (reg_wr && reg_addr == 8'h1c && (reg_wdata[9:0] & ien_q) != 10'h000
            |=> irq_q)
        else $error("enabled flag set without irq");
    chk_irq_clear:
        assert property (reg_wr && reg_addr == 8'h20 && (reg_wdata[9:0] & 10'h303) == 10'h303
            && !conv_done && !$past(conv_done) |=> !irq_q)
        else $error("irq high after clearing all flags");
    chk_halt_stop:
        assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[3] && !reg_wdata[2]
            |=> ##[0:2] !seq_active_q)
        else $error("scan still active after halt");
    chk_input_pair_mode_even:
        assert property (conv_start_q && conv_input_pair_mode_q |-> !conv_chan_q[0])
        else $error("pair started on odd input");
    chk_start_pulse:
        assert property (conv_start_q |=> !conv_start_q)
        else $error("start longer than one cycle");
    chk_flag_resvd:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h18
            |-> reg_rdata_q[31:10] == 22'h00_0000 && reg_rdata_q[7:2] == 6'h00)
        else $error("reserved flag bits set");
    chk_ien_value:
        assert property ($past(reg_rd) && $past(reg_addr) == 8'h14
            |-> reg_rdata_q == {22'h00_0000, $past(ien_q)})
        else $error("enable readback wrong");

    cover property ($rose(irq_q));
    cover property ($fell(seq_active_q));
    cover property (conv_start_q && conv_input_pair_mode_q);
endmodule : asc_scan_ctrl_props

bind asc_scan_ctrl asc_scan_ctrl_props #(.ADDR_W(ADDR_W)) u_asc_scan_ctrl_props (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q), .conv_input_pair_mode_q(conv_input_pair_mode_q),
    .conv_done(conv_done), .conv_data(conv_data), .irq_q(irq_q),
    .seq_active_q(seq_active_q)
);

// [bench/asc_scan_ctrl_tb_top.sv]
/*
 * self-checking bench of the scan control block.
 * assumes the bench stands in for the converter with a fixed latency.
 */
`timescale 1ns/100ps
module asc_scan_ctrl_tb_top;
    logic        clk_sys;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata_q;
    logic        conv_start_q;
    logic [2:0]  conv_chan_q;
    logic        conv_input_pair_mode_q;
    logic        conv_done = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic        irq_q;
    logic        seq_active_q;
    logic [11:0] samp;
    logic [31:0] v;
    logic [3:0]  chans[$];
    int          bits[4] = '{0, 1, 8, 9};
    logic [31:0] cfgs[2] = '{32'h0000_0500, 32'h0000_0602};
    logic [3:0]  ech[4]  = '{4'h0, 4'h2, 4'ha, 4'hc};
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    int          starts = 0;
    int          n0;

    asc_scan_ctrl #(.ADDR_W(8)) u_asc_scan_ctrl (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q), .conv_input_pair_mode_q(conv_input_pair_mode_q),
        .conv_done(conv_done), .conv_data(conv_data), .irq_q(irq_q),
        .seq_active_q(seq_active_q)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // converter stand-in, data scrambled outside the done pulse
    always @(posedge clk_sys) begin
        if (conv_start_q === 1'b1) begin
            starts++;
            chans.push_back({conv_input_pair_mode_q, conv_chan_q});
            repeat (3) @(posedge clk_sys);
            conv_done <= 1'b1;
            conv_data <= samp;
            @(posedge clk_sys);
            conv_done <= 1'b0;
            conv_data <= ~samp;
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic seen, input logic exp);
        chk(what, {31'h0000_0000, seen}, {31'h0000_0000, exp});
    endtask : chk_bit

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask : rd

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(what, v, e);
    endtask : rc

    task automatic wait_flag(input int b);
        for (int i = 0; i < 60; i++) begin
            rd(8'h18, v);
            if (v[b] === 1'b1) break;
        end
    endtask : wait_flag

    function automatic logic [15:0] fmt(input int res, input int result_alignment, input logic [11:0] d);
        case (res)
            0: return result_alignment ? {d, 4'h0} : {4'h0, d};
            1: return result_alignment ? {d[11:4], 8'h00} : {8'h00, d[11:4]};
            2: return result_alignment ? {d[11:6], 10'h000} : {10'h000, d[11:6]};
            default: return {d, 4'h0};
        endcase
    endfunction : fmt

    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        samp = 12'habc;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rc("enable reset", 8'h14, 32'h0000_0000);
        rc("flags reset", 8'h18, 32'h0000_0000);
        rc("unmapped", 8'h3c, 32'h0000_0000);
        wr(8'h14, 32'h0000_0303);
        rc("enable bits", 8'h14, 32'h0000_0303);
        foreach (bits[i]) begin
            wr(8'h14, 32'h0000_0001 << bits[i]);
            wr(8'h1c, 32'h0000_0303 & ~(32'h0000_0001 << bits[i]));
            chk_bit("irq other flags", irq_q, 1'b0);
            wr(8'h1c, 32'h0000_0303);
            rc("flags set", 8'h18, 32'h0000_0303);
            chk_bit("irq own flag", irq_q, 1'b1);
            wr(8'h14, 32'h0000_0000);
            chk_bit("irq masked", irq_q, 1'b0);
            wr(8'h20, 32'h0000_0303);
            rc("flags clear", 8'h18, 32'h0000_0000);
        end
        $display("test enable_gating done");
        wr(8'h04, 32'h0000_0001);
        for (int res = 0; res < 4; res++) begin
            for (int result_alignment = 0; result_alignment < 2; result_alignment++) begin
                wr(8'h10, 32'(res << 4) | 32'(result_alignment << 2));
                wr(8'h00, 32'h0000_0001);
                wait_flag(0);
                rc("single result", 8'h24, {16'h0000, fmt(res, result_alignment, samp)});
                wr(8'h20, 32'h0000_0303);
            end
        end
        $display("test resolution_alignment done");
        wr(8'h10, 32'h0000_0000);
        wr(8'h00, 32'h0000_0001);
        wait_flag(0);
        wr(8'h00, 32'h0000_0001);
        wait_flag(8);
        rc("single overflow", 8'h18, 32'h0000_0101);
        wr(8'h14, 32'h0000_0100);
        chk_bit("irq overflow", irq_q, 1'b1);
        wr(8'h20, 32'h0000_0303);
        chk_bit("irq cleared", irq_q, 1'b0);
        rd(8'h24, v);
        wr(8'h14, 32'h0000_0000);
        $display("test single_overflow done");
        for (int k = 0; k < 2; k++) begin
            chans.delete();
            wr(8'h10, cfgs[k]);
            wr(8'h00, 32'h0000_0004);
            wait_flag(1);
            repeat (10) @(posedge clk_sys);
            #1 chk("scan starts", chans.size(), 32'h0000_0002);
            chk("first input", {28'h000_0000, chans[0]}, {28'h000_0000, ech[2*k]});
            chk("second input", {28'h000_0000, chans[1]}, {28'h000_0000, ech[2*k+1]});
            chk_bit("scan ended", seq_active_q, 1'b0);
            rc("scan flags", 8'h18, 32'h0000_0202);
            rd(8'h28, v);
            wr(8'h20, 32'h0000_0303);
        end
        $display("test scan_once done");
        wr(8'h10, 32'h0000_0101);
        n0 = starts;
        wr(8'h00, 32'h0000_0004);
        repeat (40) @(posedge clk_sys);
        #1 chk_bit("scan running", seq_active_q, 1'b1);
        chk_bit("restarts", (starts - n0) >= 4, 1'b1);
        wr(8'h00, 32'h0000_0008);
        repeat (3) @(posedge clk_sys);
        n0 = starts;
        repeat (20) @(posedge clk_sys);
        #1 chk_bit("halted", seq_active_q, 1'b0);
        chk("starts after halt", starts, n0);
        $display("test repeat_scan done");
        rd(8'h28, v);
        wr(8'h20, 32'h0000_0303);
        wr(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0002);
        repeat (10) @(posedge clk_sys);
        rc("single halt flags", 8'h18, 32'h0000_0000);
        $display("test single_halt done");
        summarize();
    end
endmodule : asc_scan_ctrl_tb_top
